// file: rtl/sar_adc_sequencer.sv
// Purpose: control and sequencing of a 10-bit successive-approximation converter
// Assumes: APB slave, 32-bit data, comparator and pins arrive asynchronously
// Notes: one conversion clock period per result bit, ten periods per conversion
// How it works
// - enable bit on runs the converter, off stops it
// - idle-stop bit suspends operation while the device idles
// - trigger 000 ends sampling on clear; 111 ends it by sample counter
// - trigger 001 uses external pin edge, 010 timer match; others reserved
// - auto-sample restarts sampling after each conversion
// - sample-enable bit shows sampling versus holding; hardware sets and clears
// - done bit set at conversion end, cleared at next start, software writable
// - reference field picks internal or external references; 1xx as 000
// - scan-enable steps multiplexer A positive input through scan inputs
// - sixteen-word result buffer, optionally two halves of eight
// - fill-status shows which half hardware fills in split mode
// - interrupt after every N-th sequence, N is rate field plus one
// - alternate mode uses A first, then B and A in turn
// - clock source bit picks internal oscillator or system clock
// - sample time field gives 0 to 31 conversion clock periods
// - conversion clock period is divider plus one system cycles, up to 64
// - channel fields route positive input; negative bit picks channel 1
// - only channels set in the scan mask are scanned; an empty mask leaves channel 15
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic timer_three_match,
  input wire logic external_interrupt_zero,
  input wire logic rc_osc_clock,
  input wire logic comparator_above,
  output logic sampling,
  output logic converting,
  output logic [9:0] sar_trial,
  output logic [3:0] mux_positive,
  output logic mux_negative_ch1,
  output logic channel_valid,
  output logic vref_pos_external,
  output logic vref_neg_external,
  output logic rc_osc_enable,
  output logic converter_irq_flag
);
  // control registers
  logic enable_reg, idle_stop_reg, auto_reg, sample_enable_reg, done_reg;
  logic [1:0] fmt_reg;
  logic [2:0] trig_reg, ref_reg;
  logic scan_en_reg, split_reg, alt_reg, fill_reg, clksrc_reg;
  logic [3:0] rate_reg;
  logic [4:0] samt_reg;
  logic [7:0] div_reg;
  word_t chsel_reg, scan_mask_reg;
  // sequencer state
  seq_state_t state_reg, state_next;
  logic [4:0] sample_enable_cnt_reg, sample_enable_cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [9:0] sar_reg, sar_next;
  logic [3:0] wr_idx_reg, seq_cnt_reg, scan_ptr_reg;
  logic use_b_reg, irq_reg;
  logic [3:0] pos_reg;
  logic neg_reg, valid_reg;
  logic [2:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic sample_enable_next, done_next, start_conv, finish, end_sample, abort_sample;
  word_t con1_rd, con2_rd, con3_rd, rd_mux;
  logic hit;
  logic tad_tick;

  result_if res ();

  // bus decode
  logic setup_ph, access_ph, bus_wr, buf_sel;
  logic wr_con1, wr_con2, wr_con3, wr_chsel, wr_scan;
  logic run, irq_hit, comp_s, external_interrupt_zero_edge, rc_edge, use_a;
  logic [3:0] first_scan, next_scan_ch, sel_pos;
  logic sel_neg;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign bus_wr = access_ph & pwrite;
  assign buf_sel = (paddr >= `OFF_BUF_BASE) && (paddr <= `OFF_BUF_LAST) && (paddr[1:0] == 2'h0);
  assign wr_con1 = bus_wr & (paddr == `OFF_CON1);
  assign wr_con2 = bus_wr & (paddr == `OFF_CON2);
  assign wr_con3 = bus_wr & (paddr == `OFF_CON3);
  assign wr_chsel = bus_wr & (paddr == `OFF_CHSEL);
  assign wr_scan = bus_wr & (paddr == `OFF_SCAN);
  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit;

  // register images as software sees them
  assign con1_rd = {enable_reg, 1'b0, idle_stop_reg, 3'h0, fmt_reg, trig_reg, 2'h0,
                    auto_reg, sample_enable_reg, done_reg};
  assign con2_rd = {ref_reg, 2'h0, scan_en_reg, 2'h0, fill_reg, 1'b0, rate_reg,
                    split_reg, alt_reg};
  assign con3_rd = {clksrc_reg, 2'h0, samt_reg, div_reg};

  // read selection; buffer data was registered in the setup cycle
  always_comb begin
    hit = 1'b1;
    rd_mux = 16'h0000;
    if (paddr == `OFF_CON1) begin
      rd_mux = con1_rd;
    end else if (paddr == `OFF_CON2) begin
      rd_mux = con2_rd;
    end else if (paddr == `OFF_CON3) begin
      rd_mux = con3_rd;
    end else if (paddr == `OFF_CHSEL) begin
      rd_mux = chsel_reg;
    end else if (paddr == `OFF_SCAN) begin
      rd_mux = scan_mask_reg;
    end else if (buf_sel) begin
      rd_mux = res.rd_data;
    end else begin
      hit = 1'b0;
    end
  end
  assign prdata = (access_ph & ~pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
  assign res.rd_addr = paddr[5:2];

  // pins from outside the clock domain pass two flops; edges come from the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_prev_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {comparator_above, rc_osc_clock, external_interrupt_zero};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end
  assign external_interrupt_zero_edge = pin_sync_reg[0] & ~pin_prev_reg[0];
  assign rc_edge = pin_sync_reg[1] & ~pin_prev_reg[1];
  assign comp_s = pin_sync_reg[2];

  assign run = enable_reg & ~(idle_stop_reg & idle_mode);

  tad_divider u_tad (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .use_rc(clksrc_reg),
    .rc_edge(rc_edge),
    .divider(div_reg),
    .tad_tick(tad_tick)
  );

  // next set mask bit after a given channel, cyclic; keeps the channel if mask empty
  function automatic logic [3:0] next_in_mask(input logic [3:0] from, input word_t mask);
    logic [3:0] cand;
    logic found;
    next_in_mask = from;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      cand = from + i[3:0];
      if (!found && mask[cand]) begin
        next_in_mask = cand;
        found = 1'b1;
      end
    end
  endfunction : next_in_mask

  assign first_scan = next_in_mask(`SCAN_LAST, scan_mask_reg);
  assign next_scan_ch = next_in_mask(scan_ptr_reg, scan_mask_reg);

  // input selection: B on alternate turns, scan pointer replaces A when scanning
  assign use_a = ~use_b_reg;
  assign sel_pos = use_b_reg ? chsel_reg[`CH_B_POS_HI:`CH_B_POS_LO] :
                   scan_en_reg ? scan_ptr_reg : chsel_reg[`CH_A_POS_HI:`CH_A_POS_LO];
  assign sel_neg = use_b_reg ? chsel_reg[`CH_B_NEG] : chsel_reg[`CH_A_NEG];

  // sample end by the selected trigger; reserved codes never end it
  always_comb begin
    case (trig_reg)
      `TRIG_SOFT: end_sample = ~sample_enable_reg;
      `TRIG_EXT: end_sample = external_interrupt_zero_edge;
      `TRIG_TIMER: end_sample = timer_three_match;
      `TRIG_AUTO: end_sample = (sample_enable_cnt_reg >= samt_reg);
      default: end_sample = 1'b0;
    endcase
  end
  // with a hardware trigger, clearing the sample bit just returns to holding
  assign abort_sample = (trig_reg != `TRIG_SOFT) & ~sample_enable_reg;

  // sequencer: hold, sample, then ten conversion periods
  always_comb begin
    state_next = state_reg;
    sample_enable_cnt_next = sample_enable_cnt_reg;
    bit_next = bit_reg;
    sar_next = sar_reg;
    start_conv = 1'b0;
    finish = 1'b0;
    if (!enable_reg) begin
      state_next = st_hold;
    end else if (run) begin
      case (state_reg)
        st_hold: begin
          if (sample_enable_reg) begin
            state_next = st_sample;
            sample_enable_cnt_next = 5'h00;
          end
        end
        st_sample: begin
          sar_next = `SAR_FIRST; // trial settles early
          if (tad_tick && sample_enable_cnt_reg != 5'h1F) begin
            sample_enable_cnt_next = sample_enable_cnt_reg + 5'h01;
          end
          if (abort_sample) begin
            state_next = st_hold;
          end else if (end_sample) begin
            state_next = st_convert;
            start_conv = 1'b1;
            bit_next = `SAR_MSB;
          end
        end
        st_convert: begin
          if (tad_tick) begin
            if (!comp_s) begin
              sar_next[bit_reg] = 1'b0;
            end
            if (bit_reg == 4'h0) begin
              finish = 1'b1;
              state_next = auto_reg ? st_sample : st_hold;
              sample_enable_cnt_next = 5'h00;
            end else begin
              sar_next[bit_reg - 4'h1] = 1'b1;
              bit_next = bit_reg - 4'h1;
            end
          end
        end
        default: state_next = st_hold;
      endcase
    end
  end

  assign irq_hit = finish & (seq_cnt_reg == rate_reg);

  // hardware events come last so a set beats a software clear in the same cycle
  always_comb begin
    sample_enable_next = wr_con1 ? pwdata[`C1_SAMPLE_ENABLE] : sample_enable_reg;
    if (start_conv) begin
      sample_enable_next = 1'b0;
    end
    if (finish && auto_reg) begin
      sample_enable_next = 1'b1;
    end
    done_next = wr_con1 ? pwdata[`C1_DONE] : done_reg;
    if (start_conv) begin
      done_next = 1'b0;
    end
    if (finish) begin
      done_next = 1'b1;
    end
  end

  // result formatting at write time
  always_comb begin
    case (fmt_reg)
      `FMT_UINT: res.wr_data = {6'h00, sar_next};
      `FMT_SINT: res.wr_data = {{7{~sar_next[9]}}, sar_next[8:0]};
      `FMT_FRAC: res.wr_data = {sar_next, 6'h00};
      default: res.wr_data = {~sar_next[9], sar_next[8:0], 6'h00};
    endcase
  end
  assign res.wr_en = finish;
  assign res.wr_addr = split_reg ? {fill_reg, wr_idx_reg[2:0]} : wr_idx_reg;

  result_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .mem(res)
  );

  // software-written control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {enable_reg, idle_stop_reg, fmt_reg, trig_reg, auto_reg} <= 8'h00;
      {ref_reg, scan_en_reg, rate_reg, split_reg, alt_reg} <= 10'h000;
      {clksrc_reg, samt_reg, div_reg} <= 14'h0000;
      chsel_reg <= 16'h0000;
      scan_mask_reg <= 16'h0000;
    end else begin
      if (wr_con1) begin
        enable_reg <= pwdata[`C1_ENABLE];
        idle_stop_reg <= pwdata[`C1_IDLE_STOP];
        fmt_reg <= pwdata[`C1_FMT_HI:`C1_FMT_LO];
        trig_reg <= pwdata[`C1_TRIG_HI:`C1_TRIG_LO];
        auto_reg <= pwdata[`C1_AUTO];
      end
      if (wr_con2) begin
        ref_reg <= pwdata[`C2_REF_HI:`C2_REF_LO];
        scan_en_reg <= pwdata[`C2_SCAN];
        rate_reg <= pwdata[`C2_RATE_HI:`C2_RATE_LO];
        split_reg <= pwdata[`C2_SPLIT];
        alt_reg <= pwdata[`C2_ALT];
      end
      if (wr_con3) begin
        {clksrc_reg, samt_reg, div_reg} <= {pwdata[`C3_CLKSRC], pwdata[`C3_SAMT_HI:`C3_DIV_LO]};
      end
      if (wr_chsel) begin
        chsel_reg <= pwdata[15:0] & `CHSEL_WMASK;
      end
      if (wr_scan) begin
        scan_mask_reg <= pwdata[15:0] & `SCAN_WMASK;
      end
    end
  end

  // sequencer and handshake bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_hold;
      sample_enable_cnt_reg <= 5'h00;
      bit_reg <= 4'h0;
      sar_reg <= 10'h000;
      sample_enable_reg <= 1'b0;
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sample_enable_cnt_reg <= sample_enable_cnt_next;
      bit_reg <= bit_next;
      sar_reg <= sar_next;
      sample_enable_reg <= sample_enable_next;
      done_reg <= done_next;
      irq_reg <= irq_hit;
    end
  end

  // buffer pointer, sequence count, alternate and scan position
  // all rewind while off so that each enable starts a fresh pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_idx_reg <= 4'h0;
      seq_cnt_reg <= 4'h0;
      fill_reg <= 1'b0;
      use_b_reg <= 1'b0;
      scan_ptr_reg <= 4'h0;
    end else if (!enable_reg) begin
      wr_idx_reg <= 4'h0;
      seq_cnt_reg <= 4'h0;
      fill_reg <= 1'b0;
      use_b_reg <= 1'b0;
      scan_ptr_reg <= first_scan;
    end else if (finish) begin
      wr_idx_reg <= irq_hit ? 4'h0 : wr_idx_reg + 4'h1;
      seq_cnt_reg <= irq_hit ? 4'h0 : seq_cnt_reg + 4'h1;
      fill_reg <= fill_reg ^ (irq_hit & split_reg);
      use_b_reg <= alt_reg & ~irq_hit & ~use_b_reg;
      if (irq_hit) begin
        scan_ptr_reg <= first_scan;
      end else if (use_a) begin
        scan_ptr_reg <= next_scan_ch;
      end
    end
  end

  // analog-facing selections, registered so they never glitch mid-sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= 4'h0;
      neg_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      pos_reg <= sel_pos;
      neg_reg <= sel_neg;
      valid_reg <= (sel_pos != `CH_UNIMPL_LO) && (sel_pos != `CH_UNIMPL_HI);
    end
  end

  assign sampling = (state_reg == st_sample);
  assign converting = (state_reg == st_convert);
  assign sar_trial = sar_reg;
  assign mux_positive = pos_reg;
  assign mux_negative_ch1 = neg_reg;
  assign channel_valid = valid_reg;
  // reserved reference codes fall back to the internal pair
  assign vref_pos_external = ~ref_reg[`REF_RSVD_BIT] & ref_reg[`REF_POS_BIT];
  assign vref_neg_external = ~ref_reg[`REF_RSVD_BIT] & ref_reg[`REF_NEG_BIT];
  assign rc_osc_enable = enable_reg & clksrc_reg;
  assign converter_irq_flag = irq_reg;
endmodule : sar_adc_sequencer

// file: rtl/sar_adc_consts.svh
// Purpose: named offsets, field positions, masks and codes of the converter sequencer
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// byte offsets on the register bus
`define OFF_CON1 8'h00
`define OFF_CON2 8'h04
`define OFF_CON3 8'h08
`define OFF_CHSEL 8'h0C
`define OFF_SCAN 8'h10
`define OFF_BUF_BASE 8'h40
`define OFF_BUF_LAST 8'h7C

// writable bits of each register
`define CON1_WMASK 16'hA3E7
`define CON2_WMASK 16'hE43F
`define CON3_WMASK 16'h9FFF
`define CHSEL_WMASK 16'h8F8F
`define SCAN_WMASK 16'h9FFF

// control one fields
`define C1_ENABLE 15
`define C1_IDLE_STOP 13
`define C1_FMT_HI 9
`define C1_FMT_LO 8
`define C1_TRIG_HI 7
`define C1_TRIG_LO 5
`define C1_AUTO 2
`define C1_SAMPLE_ENABLE 1
`define C1_DONE 0

// control two fields
`define C2_REF_HI 15
`define C2_REF_LO 13
`define C2_SCAN 10
`define C2_FILL 7
`define C2_RATE_HI 5
`define C2_RATE_LO 2
`define C2_SPLIT 1
`define C2_ALT 0

// control three fields
`define C3_CLKSRC 15
`define C3_SAMT_HI 12
`define C3_SAMT_LO 8
`define C3_DIV_HI 7
`define C3_DIV_LO 0

// channel select fields
`define CH_B_NEG 15
`define CH_B_POS_HI 11
`define CH_B_POS_LO 8
`define CH_A_NEG 7
`define CH_A_POS_HI 3
`define CH_A_POS_LO 0

// codes
`define TRIG_SOFT 3'h0
`define TRIG_EXT 3'h1
`define TRIG_TIMER 3'h2
`define TRIG_AUTO 3'h7
`define FMT_UINT 2'h0
`define FMT_SINT 2'h1
`define FMT_FRAC 2'h2
`define FMT_SFRAC 2'h3
`define REF_POS_BIT 0
`define REF_NEG_BIT 1
`define REF_RSVD_BIT 2
`define CH_UNIMPL_LO 4'hD
`define CH_UNIMPL_HI 4'hE
`define DIV_MAX 8'h3F
`define SAR_FIRST 10'h200
`define SAR_MSB 4'h9
`define SCAN_LAST 4'hF

`endif

// file: rtl/sar_adc_pkg.sv
// Purpose: shared types of the converter sequencer
// Assumes: nothing
// Notes: numbers live in sar_adc_consts.svh
package sar_adc_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {st_hold, st_sample, st_convert} seq_state_t;
endpackage : sar_adc_pkg

// file: rtl/result_if.sv
// Purpose: link between sequencer and result store
// Assumes: one writer, one reader, same clock
// Notes: read data is registered in the store
`timescale 1ns/1ps
interface result_if;
  import sar_adc_pkg::*;
  logic wr_en;
  logic [3:0] wr_addr;
  word_t wr_data;
  logic [3:0] rd_addr;
  word_t rd_data;
  modport writer(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : result_if

// file: rtl/result_mem.sv
// Purpose: sixteen-word result store
// Assumes: address held steady for the cycle before data is used
// Notes: read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
module result_mem
  import sar_adc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  result_if.store mem
);
  word_t words [16];

  // write port; contents are not reset, software must not trust them before a fill
  always_ff @(posedge pclk) begin
    if (mem.wr_en) begin
      words[mem.wr_addr] <= mem.wr_data;
    end
  end

  // registered read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem.rd_data <= 16'h0000;
    end else begin
      mem.rd_data <= words[mem.rd_addr];
    end
  end
endmodule : result_mem

// file: rtl/tad_divider.sv
// Purpose: conversion clock period enable
// Assumes: rc_edge is already synchronised and is one cycle long
// Notes: reserved divider values are clamped to the largest legal one
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module tad_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic use_rc,
  input wire logic rc_edge,
  input wire logic [7:0] divider,
  output logic tad_tick
);
  logic [7:0] count_reg;
  logic [7:0] limit;
  logic wrap;

  // period is divider plus one system cycles
  assign limit = (divider > `DIV_MAX) ? `DIV_MAX : divider;
  assign wrap = (count_reg >= limit);

  // counter clears to zero and ticks stop while the converter is off or suspended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h00;
      tad_tick <= 1'b0;
    end else if (!run) begin
      count_reg <= 8'h00;
      tad_tick <= 1'b0;
    end else if (use_rc) begin
      count_reg <= 8'h00;
      tad_tick <= rc_edge;
    end else begin
      count_reg <= wrap ? 8'h00 : count_reg + 8'h01;
      tad_tick <= wrap;
    end
  end
endmodule : tad_divider

// file: tb/sar_adc_sequencer_checker.sv
// Purpose: port checks of the converter sequencer
// Assumes: control bits mirrored from bus writes
// Notes: bound to the top module
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module sar_adc_sequencer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic idle_mode,
  input wire logic timer_three_match,
  input wire logic sampling,
  input wire logic converting,
  input wire logic [9:0] sar_trial,
  input wire logic [3:0] mux_positive,
  input wire logic channel_valid,
  input wire logic vref_pos_external,
  input wire logic vref_neg_external,
  input wire logic rc_osc_enable,
  input wire logic converter_irq_flag
);
  logic [15:0] c1_q;
  logic [15:0] c2_q;
  logic src_q;
  logic conv_d;
  logic [3:0] seq_cnt;
  // write strobe and end of a finished conversion
  wire wr = psel && penable && pwrite;
  wire done_ev = conv_d && !converting && c1_q[15];
  // software view only; hardware-owned bits are not used here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
      src_q <= 1'b0;
    end else if (wr) begin
      if (paddr == `OFF_CON1) c1_q <= pwdata[15:0];
      if (paddr == `OFF_CON2) c2_q <= pwdata[15:0];
      if (paddr == `OFF_CON3) src_q <= pwdata[15];
    end
  end
  // completions since the last interrupt, rewound on disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_d <= 1'b0;
      seq_cnt <= 4'h0;
    end else begin
      conv_d <= converting;
      if (converter_irq_flag || !c1_q[15]) seq_cnt <= 4'h0;
      else if (done_ev) seq_cnt <= seq_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_done;
    done_ev;
  endsequence
  sequence s_idle;
    (idle_mode && c1_q[13] && c1_q[15]) [*3];
  endsequence
  AST_OFF_QUIET: assert property ((!c1_q[15]) [*2] |-> !converting)
    else $error("converting while off");
  AST_IDLE_FREEZE: assert property (s_idle |-> $stable(sar_trial) && $stable(converting))
    else $error("moved while idle stopped");
  AST_START_MSB: assert property ($rose(converting) |-> sar_trial == `SAR_FIRST && !sampling)
    else $error("bad conversion start");
  AST_TIMER_END: assert property (timer_three_match && sampling && c1_q[15] && !idle_mode
    && c1_q[7:5] == `TRIG_TIMER |-> ##[1:3] converting) else $error("match ignored");
  AST_AUTO_RESAMPLE: assert property (s_done ##0 c1_q[2] |-> ##[0:2] sampling)
    else $error("no auto sampling");
  AST_IRQ_NTH: assert property (s_done ##0 (seq_cnt == c2_q[5:2])
    |-> ##[0:2] converter_irq_flag) else $error("missing interrupt");
  AST_IRQ_EARLY: assert property (s_done ##0 (seq_cnt != c2_q[5:2])
    |-> !converter_irq_flag [*3]) else $error("early interrupt");
  AST_REF_PINS: assert property ({vref_pos_external, vref_neg_external}
    == {!c2_q[15] && c2_q[13], !c2_q[15] && c2_q[14]}) else $error("bad references");
  AST_RC_ENABLE: assert property (rc_osc_enable == (c1_q[15] && src_q))
    else $error("bad oscillator enable");
  AST_CHAN_UNIMPL: assert property (channel_valid |-> !(mux_positive inside {4'hD, 4'hE}))
    else $error("unimplemented channel valid");
endmodule : sar_adc_sequencer_checker
bind sar_adc_sequencer sar_adc_sequencer_checker sar_adc_sequencer_checker_inst (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .idle_mode, .timer_three_match,
  .sampling, .converting, .sar_trial, .mux_positive, .channel_valid, .vref_pos_external,
  .vref_neg_external, .rc_osc_enable, .converter_irq_flag);

// file: tb/analog_front_end.sv
// Purpose: sample-hold and comparator model on the far side
// Assumes: each valid channel carries the fixed code {channel, 6'h2A}; channels D and E give 0
// Notes: tracks only while sampling, holds otherwise
`timescale 1ns/1ps
module analog_front_end (
  input wire logic pclk,
  input wire logic sampling,
  input wire logic [3:0] mux_positive,
  input wire logic channel_valid,
  input wire logic [9:0] sar_trial,
  output logic comparator_above
);
  logic [9:0] held = 10'h155;
  // the cap follows the routed input only while sampling
  always @(posedge pclk) begin
    if (sampling) held <= channel_valid ? {mux_positive, 6'h2A} : 10'h000;
  end
  // exact decision, no margin given to the converter
  assign comparator_above = (held >= sar_trial);
endmodule : analog_front_end

// file: tb/sar_adc_sequencer_bench.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: far side is analog_front_end with fixed channel levels
// Notes: expected words follow those levels
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module sar_adc_sequencer_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic idle_mode = 1'b0, timer_three_match = 1'b0, external_interrupt_zero = 1'b0;
  logic rc_osc_clock = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] ch;
  wire logic [31:0] prdata;
  wire logic [9:0] sar_trial;
  wire logic [3:0] mux_positive;
  wire logic pready, pslverr, comparator_above, sampling, converting, channel_valid;
  wire logic vref_pos_external, vref_neg_external, rc_osc_enable, converter_irq_flag;
  int n_mismatch = 0, cmp_count = 0, n_irq = 0, cycles = 0, f, k;
  sar_adc_sequencer sar_adc_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .idle_mode, .timer_three_match,
    .external_interrupt_zero, .rc_osc_clock, .comparator_above, .sampling, .converting,
    .sar_trial, .mux_positive, .mux_negative_ch1(), .channel_valid, .vref_pos_external,
    .vref_neg_external, .rc_osc_enable, .converter_irq_flag);
  analog_front_end analog_front_end_inst (.pclk, .sampling, .mux_positive, .channel_valid,
    .sar_trial, .comparator_above);
  // system clock and a free, unrelated oscillator
  initial begin
    forever #4 pclk = ~pclk;
  end
  initial begin
    forever #47.3 rc_osc_clock = ~rc_osc_clock;
  end
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // interrupt count and hang guard
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (converter_irq_flag === 1'b1) n_irq <= n_irq + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one setup and access; held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    check(rd, {16'h0000, e});
  endtask : rd_chk
  task automatic wait_done();
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, `OFF_CON1, 16'h0000);
      if (rd[`C1_DONE] === 1'b1) break;
    end
    check({31'h0, rd[`C1_DONE]}, 32'h1);
  endtask : wait_done
  task automatic wait_irq(input int n);
    for (int i = 0; i < 3000 && n_irq < n; i++) @(posedge pclk);
    check({31'h0, n_irq >= n}, 32'h1);
  endtask : wait_irq
  function automatic logic [15:0] res(input logic [3:0] c, input logic [1:0] fm);
    logic [9:0] r;
    r = {c, 6'h2A};
    case (fm)
      2'h0: return {6'h00, r};
      2'h1: return {{7{~r[9]}}, r[8:0]};
      2'h2: return {r, 6'h00};
      default: return {~r[9], r[8:0], 6'h00};
    endcase
  endfunction : res
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, masks, refused places
    for (k = 0; k < 5; k++) rd_chk(8'(4 * k), 16'h0000);
    apb(1'b1, `OFF_CON3, 16'hFFFF);
    rd_chk(`OFF_CON3, 16'h9FFF);
    rd_chk(8'h20, 16'h0000);
    check({31'h0, err}, 32'h1);
    // every reference code, reserved ones too
    for (k = 0; k < 8; k++) begin
      apb(1'b1, `OFF_CON2, 16'(k << 13));
      @(negedge pclk);
      check({vref_pos_external, vref_neg_external}, {k < 4 && k[0], k < 4 && k[1]});
    end
    // software-ended conversions in each format; idle stop in one, oscillator in another
    apb(1'b1, `OFF_CON2, 16'h0000);
    for (f = 0; f < 4; f++) begin
      ch = {f[0], 3'h1};
      apb(1'b1, `OFF_CHSEL, {12'h000, ch});
      apb(1'b1, `OFF_CON3, f == 3 ? 16'h8004 : 16'h0004);
      apb(1'b1, `OFF_CON1, 16'hA002 | 16'(f << 8));
      repeat (4) @(posedge pclk);
      apb(1'b1, `OFF_CON1, 16'hA000 | 16'(f << 8));
      if (f == 2) begin
        idle_mode <= 1'b1;
        repeat (20) @(posedge pclk);
        idle_mode <= 1'b0;
      end
      wait_done();
      rd_chk(`OFF_BUF_BASE, res(ch, f[1:0]));
      apb(1'b1, `OFF_CON1, 16'h0000);
    end
    apb(1'b1, `OFF_BUF_BASE, 16'h1234);
    rd_chk(`OFF_BUF_BASE, res(4'h9, 2'h3));
    // pin edge, timer match, then reserved codes that never end sampling
    apb(1'b1, `OFF_CHSEL, 16'h0005);
    for (k = 1; k < 7; k++) begin
      apb(1'b1, `OFF_CON1, 16'h8002 | 16'(k << 5));
      repeat (4) @(posedge pclk);
      timer_three_match <= 1'b1;
      external_interrupt_zero <= 1'b1;
      @(posedge pclk);
      timer_three_match <= 1'b0;
      repeat (6) @(posedge pclk);
      external_interrupt_zero <= 1'b0;
      if (k < 3) begin
        wait_done();
        rd_chk(`OFF_BUF_BASE, res(4'h5, 2'h0));
      end else begin
        @(negedge pclk);
        check({31'h0, sampling}, 32'h1);
      end
      apb(1'b1, `OFF_CON1, 16'h0000);
    end
    // auto runs: alternating inputs per 4th, then scan into split halves
    apb(1'b1, `OFF_CON3, 16'h0204);
    apb(1'b1, `OFF_CHSEL, 16'h0905);
    apb(1'b1, `OFF_SCAN, 16'h1008);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, `OFF_CON2, k ? 16'h0406 : 16'h000D);
      apb(1'b1, `OFF_CON1, 16'h80E6);
      wait_irq(n_irq + 1);
      if (k) begin
        rd_chk(`OFF_CON2, 16'h0486);
        wait_irq(n_irq + 1);
      end
      apb(1'b1, `OFF_CON1, 16'h0000);
      for (f = 0; f < 4; f++) begin
        ch = k ? (f[0] ? 4'hC : 4'h3) : (f[0] ? 4'h9 : 4'h5);
        rd_chk(`OFF_BUF_BASE + 8'(k ? 4 * f[0] + 32 * f[1] : 4 * f), res(ch, 2'h0));
      end
    end
    end_of_test();
  end
endmodule : sar_adc_sequencer_bench
